// File: rtl/pic_ctrl.sv
/*
 * Priority selection, event coding and NMI edge detection for on-chip peripheral requests.
 * Assumes peripheral request lines are levels on clk_sys held until their cause is cleared,
 * the NMI pin is asynchronous, and the core gives its mask and acknowledges on clk_sys.
 */
`timescale 1ns/10ps
`default_nettype none

module pic_ctrl (
	// Clock and reset
	input  wire logic                              clk_sys,
	input  wire logic                              nrst,
	// Register port
	input  wire logic [pic_pkg::PIC_ADDR_W-1:0]    reg_addr,
	input  wire logic [15:0]                       reg_wdata,
	input  wire logic                              reg_wr,
	input  wire logic                              reg_rd,
	output logic      [15:0]                       reg_rdata,
	// Peripheral requests in default order
	input  wire logic [pic_pkg::PIC_NUM_CAUSES-1:0] periph_req,
	// NMI pin
	input  wire logic                              nmi_pin,
	// Processor core
	input  wire logic [3:0]                        cpu_int_mask,
	input  wire logic                              nmi_ack,
	output logic                                   cpu_irq_req,
	output logic      [3:0]                        cpu_irq_level,
	output logic      [11:0]                       event_code_reg,
	output logic                                   nmi_req,
	// Interrupt to software
	output logic                                   irq
);

	// ****************************************************************
	// State
	// ****************************************************************
	pic_pkg::pic_state_t st_ff;
	pic_pkg::pic_state_t nxt_st;

	logic [31:0] prio_all;
	logic [3:0]  best_lvl;
	logic [3:0]  cause_lvl;
	logic [3:0]  best_idx;
	logic        found;
	logic        nmi_rise;
	logic        nmi_fall;
	logic        nmi_edge;
	logic        wr_a;
	logic        wr_b;
	logic        wr_nmi;
	logic        wr_st;
	logic        wr_msk;
	logic [1:0]  st_set;

	assign reg_rdata      = st_ff.rdata;
	assign cpu_irq_req    = st_ff.cpu_req;
	assign cpu_irq_level  = st_ff.cpu_lvl;
	assign event_code_reg = st_ff.code;
	assign nmi_req        = st_ff.nmi_req;
	assign irq            = st_ff.irq;

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		nxt_st    = st_ff;
		wr_a      = reg_wr && (reg_addr == pic_pkg::PIC_OFS_PRIO_A);
		wr_b      = reg_wr && (reg_addr == pic_pkg::PIC_OFS_PRIO_B);
		wr_nmi    = reg_wr && (reg_addr == pic_pkg::PIC_OFS_NMI_CTRL);
		wr_st     = reg_wr && (reg_addr == pic_pkg::PIC_OFS_STATUS);
		wr_msk    = reg_wr && (reg_addr == pic_pkg::PIC_OFS_MASK);

		// Priority registers; the low field of the second is held at zero.
		if (wr_a) begin
			nxt_st.prio_a = reg_wdata;
		end
		if (wr_b) begin
			nxt_st.prio_b = reg_wdata & pic_pkg::PIC_PRIO_B_WR_MASK;
		end
		if (wr_nmi) begin
			nxt_st.edge_sel = reg_wdata[pic_pkg::PIC_NMI_EDGE_BIT];
		end
		if (wr_msk) begin
			nxt_st.mask = reg_wdata[1:0];
		end

		// NMI pin synchroniser and edge detection on the second stage only.
		nxt_st.nmi_s1   = nmi_pin;
		nxt_st.nmi_s2   = st_ff.nmi_s1;
		nxt_st.nmi_prev = st_ff.nmi_s2;
		nmi_rise        = st_ff.nmi_s2 && !st_ff.nmi_prev;
		nmi_fall        = !st_ff.nmi_s2 && st_ff.nmi_prev;
		nmi_edge        = st_ff.edge_sel ? nmi_rise : nmi_fall;
		// A new edge in the acknowledge cycle keeps the request pending.
		nxt_st.nmi_req  = nmi_edge || (st_ff.nmi_req && !nmi_ack);

		// Arbitration reads the registered fields, so a write counts next cycle.
		prio_all = {st_ff.prio_a, st_ff.prio_b};
		best_lvl = 4'h0;
		cause_lvl = 4'h0;
		best_idx = 4'h0;
		found    = 1'b0;
		for (int i = 0; i < pic_pkg::PIC_NUM_CAUSES; i++) begin
			cause_lvl = prio_all[31 - 4 * int'(pic_pkg::PIC_CAUSE_FIELD[i]) -: 4];
			// Strictly greater: level zero never wins, ties keep the earlier cause.
			if (periph_req[i] && (cause_lvl > best_lvl)) begin
				best_lvl = cause_lvl;
				best_idx = 4'(i);
				found    = 1'b1;
			end
		end
		nxt_st.cpu_req = found && (best_lvl > cpu_int_mask);
		nxt_st.cpu_lvl = found ? best_lvl : 4'h0;
		if (nxt_st.nmi_req) begin
			nxt_st.code = pic_pkg::PIC_NMI_CODE;
		end else if (found) begin
			nxt_st.code = pic_pkg::PIC_CAUSE_CODE[best_idx];
		end else begin
			nxt_st.code = pic_pkg::PIC_NONE_CODE;
		end

		// Sticky status; a new event beats a write-one clear in the same cycle.
		st_set                              = 2'h0;
		st_set[pic_pkg::PIC_ST_NMI_BIT]     = nmi_edge;
		st_set[pic_pkg::PIC_ST_FWD_BIT]     = nxt_st.cpu_req && !st_ff.cpu_req;
		nxt_st.status = (st_ff.status & ~(wr_st ? reg_wdata[1:0] : 2'h0)) | st_set;
		nxt_st.irq    = |(nxt_st.status & nxt_st.mask);

		// Read data stand in the cycle after the strobe only.
		nxt_st.rdata = 16'h0000;
		if (reg_rd) begin
			case (reg_addr)
				pic_pkg::PIC_OFS_PRIO_A: begin
					nxt_st.rdata = st_ff.prio_a;
				end
				pic_pkg::PIC_OFS_PRIO_B: begin
					nxt_st.rdata = st_ff.prio_b & pic_pkg::PIC_PRIO_B_WR_MASK;
				end
				pic_pkg::PIC_OFS_NMI_CTRL: begin
					nxt_st.rdata[pic_pkg::PIC_NMI_LEVEL_BIT] = st_ff.nmi_s2;
					nxt_st.rdata[pic_pkg::PIC_NMI_EDGE_BIT]  = st_ff.edge_sel;
				end
				pic_pkg::PIC_OFS_STATUS: begin
					nxt_st.rdata[1:0] = st_ff.status;
				end
				pic_pkg::PIC_OFS_MASK: begin
					nxt_st.rdata[1:0] = st_ff.mask;
				end
				default: begin
					nxt_st.rdata = 16'h0000;
				end
			endcase
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st_ff <= pic_pkg::PIC_STATE_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);

	a_prio_a_write: assert property (
		reg_wr && reg_addr == pic_pkg::PIC_OFS_PRIO_A
		|=> st_ff.prio_a == $past(reg_wdata))
		else $error("first priority register lost a write");

	a_prio_b_write: assert property (
		reg_wr && reg_addr == pic_pkg::PIC_OFS_PRIO_B
		|=> st_ff.prio_b == ($past(reg_wdata) & pic_pkg::PIC_PRIO_B_WR_MASK))
		else $error("second priority register lost a write");

	a_resv_b_zero: assert property (
		reg_rd && reg_addr == pic_pkg::PIC_OFS_PRIO_B |=> reg_rdata[3:0] == 4'h0)
		else $error("reserved priority field read not zero");

	a_nmi_resv_zero: assert property (
		reg_rd && reg_addr == pic_pkg::PIC_OFS_NMI_CTRL
		|=> (reg_rdata & pic_pkg::PIC_NMI_RESV_MASK) == 16'h0000)
		else $error("reserved NMI control bits read not zero");

	a_nmi_level_live: assert property (
		reg_rd && reg_addr == pic_pkg::PIC_OFS_NMI_CTRL
		|=> reg_rdata[pic_pkg::PIC_NMI_LEVEL_BIT] == $past(st_ff.nmi_s2))
		else $error("NMI level bit does not follow pin");

	a_edge_sel_hold: assert property (
		!$stable(st_ff.edge_sel)
		|-> $past(reg_wr && reg_addr == pic_pkg::PIC_OFS_NMI_CTRL))
		else $error("edge select changed without a write");

	a_nmi_fall_set: assert property (
		!st_ff.edge_sel && st_ff.nmi_s2
		##1 !st_ff.edge_sel && !st_ff.nmi_s2 |=> nmi_req)
		else $error("falling NMI edge not latched");

	a_nmi_rise_set: assert property (
		st_ff.edge_sel && !st_ff.nmi_s2
		##1 st_ff.edge_sel && st_ff.nmi_s2 |=> nmi_req)
		else $error("rising NMI edge not latched");

	a_nmi_code_over: assert property (
		nmi_req
		|-> event_code_reg == pic_pkg::PIC_NMI_CODE)
		else $error("pending NMI not shown in event code");

	a_nmi_pend_hold: assert property (
		nmi_req && !nmi_ack |=> nmi_req)
		else $error("NMI request dropped before acknowledge");

	a_fwd_above_mask: assert property (
		cpu_irq_req |-> cpu_irq_level > $past(cpu_int_mask))
		else $error("request forwarded at or below core mask");

	a_zero_level_masks: assert property (
		cpu_irq_req |-> cpu_irq_level != 4'h0)
		else $error("level zero request forwarded");

	a_code_alarm: assert property (
		periph_req == pic_pkg::PIC_REQ_ALARM_ONLY && st_ff.prio_a[3:0] > cpu_int_mask
		&& !st_ff.nmi_req && !nmi_edge
		|=> cpu_irq_req && event_code_reg == 12'h480)
		else $error("alarm request not coded correctly");

	a_code_clock: assert property (
		event_code_reg inside {12'h480, 12'h4A0, 12'h4C0}
		|-> cpu_irq_level == $past(st_ff.prio_a[3:0]))
		else $error("clock unit code with wrong level");

	a_code_serial: assert property (
		event_code_reg inside {12'h4E0, 12'h500, 12'h520, 12'h540}
		|-> cpu_irq_level == $past(st_ff.prio_b[7:4]))
		else $error("serial unit code with wrong level");

	a_code_watchdog: assert property (
		event_code_reg == 12'h560
		|-> cpu_irq_level == $past(st_ff.prio_b[15:12]))
		else $error("watchdog code with wrong level");

	a_code_refresh: assert property (
		event_code_reg inside {12'h580, 12'h5A0}
		|-> cpu_irq_level == $past(st_ff.prio_b[11:8]))
		else $error("refresh unit code with wrong level");

	a_alarm_order: assert property (
		periph_req[4] && st_ff.prio_a[3:0] != 4'h0
		|=> !(event_code_reg inside {12'h4A0, 12'h4C0}))
		else $error("alarm lost to a lower clock unit cause");

	a_serial_order: assert property (
		periph_req[7] && st_ff.prio_b[7:4] != 4'h0
		|=> !(event_code_reg inside {12'h500, 12'h520, 12'h540}))
		else $error("receive error lost to a lower serial cause");

	a_refresh_order: assert property (
		periph_req[12] && st_ff.prio_b[11:8] != 4'h0
		|=> event_code_reg != 12'h5A0)
		else $error("overflow won over compare match");

	a_tie_default: assert property (
		periph_req[0] && st_ff.prio_a[15:12] != 4'h0
		|=> nmi_req || event_code_reg == 12'h400
			|| cpu_irq_level > $past(st_ff.prio_a[15:12]))
		else $error("equal level tie not resolved in default order");

	c_nmi_taken: cover property (nmi_req ##[1:20] nmi_ack);
	c_periph_fwd: cover property (!cpu_irq_req ##1 cpu_irq_req);
	c_tie_order: cover property (periph_req[pic_pkg::PIC_C_ALARM] && periph_req[0]
		&& st_ff.prio_a[15:12] == st_ff.prio_a[3:0] ##1 cpu_irq_req);
	c_irq_out: cover property (!irq ##1 irq);
	c_nmi_rise: cover property (st_ff.edge_sel && nmi_edge ##1 nmi_req);

endmodule : pic_ctrl

`default_nettype wire

// File: rtl/pic_pkg.sv
/*
 * Constants and the state type of the peripheral interrupt priority and NMI controller.
 * Assumes a single peripheral clock domain and a plain strobe-based register port.
 */
`default_nettype none

package pic_pkg;

	// ****************************************************************
	// Sizes
	// ****************************************************************
	localparam int PIC_NUM_CAUSES = 14;
	localparam int PIC_ADDR_W     = 8;

	// ****************************************************************
	// Register offsets
	// ****************************************************************
	localparam logic [7:0] PIC_OFS_PRIO_A   = 8'h00;
	localparam logic [7:0] PIC_OFS_PRIO_B   = 8'h04;
	localparam logic [7:0] PIC_OFS_NMI_CTRL = 8'h08;
	localparam logic [7:0] PIC_OFS_STATUS   = 8'h0C;
	localparam logic [7:0] PIC_OFS_MASK     = 8'h10;

	// ****************************************************************
	// Field layouts and reset values
	// ****************************************************************
	localparam logic [15:0] PIC_PRIO_RST        = 16'h0000;
	localparam logic [15:0] PIC_PRIO_B_WR_MASK  = 16'hFFF0;
	localparam int          PIC_NMI_LEVEL_BIT   = 15;
	localparam int          PIC_NMI_EDGE_BIT    = 8;
	localparam logic [15:0] PIC_NMI_RESV_MASK   = 16'h7EFF;
	localparam int          PIC_ST_NMI_BIT      = 0;
	localparam int          PIC_ST_FWD_BIT      = 1;
	localparam logic [1:0]  PIC_ST_RST          = 2'h0;

	// ****************************************************************
	// Causes in default order, their priority field and event code
	// ****************************************************************
	localparam int PIC_C_ALARM = 4;
	localparam logic [13:0] PIC_REQ_ALARM_ONLY = 14'h0010;

	// Field 0..3 are the first register top to bottom, 4..6 the second.
	localparam logic [2:0] PIC_CAUSE_FIELD [PIC_NUM_CAUSES] = '{
		3'h0, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3, 3'h3,
		3'h6, 3'h6, 3'h6, 3'h6, 3'h4, 3'h5, 3'h5
	};

	localparam logic [11:0] PIC_CAUSE_CODE [PIC_NUM_CAUSES] = '{
		12'h400, 12'h420, 12'h440, 12'h460,
		12'h480, 12'h4A0, 12'h4C0,
		12'h4E0, 12'h500, 12'h520, 12'h540,
		12'h560, 12'h580, 12'h5A0
	};

	localparam logic [11:0] PIC_NMI_CODE  = 12'h1C0;
	localparam logic [11:0] PIC_NONE_CODE = 12'h000;

	// ****************************************************************
	// State of the controller
	// ****************************************************************
	typedef struct packed {
		logic [15:0] prio_a;
		logic [15:0] prio_b;
		logic        edge_sel;
		logic        nmi_s1;
		logic        nmi_s2;
		logic        nmi_prev;
		logic        nmi_req;
		logic [1:0]  status;
		logic [1:0]  mask;
		logic        irq;
		logic        cpu_req;
		logic [3:0]  cpu_lvl;
		logic [11:0] code;
		logic [15:0] rdata;
	} pic_state_t;

	localparam pic_state_t PIC_STATE_RST = '0;

endpackage : pic_pkg

`default_nettype wire

// File: verification/pic_core_model.sv
/*
 * Behavioural model of the processor core side of the NMI handshake.
 * Assumes nmi_req is a level on clk_sys; the acknowledge pace is set by the bench.
 */
`timescale 1ns/10ps
`default_nettype none

module pic_core_model (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       nrst,
	// Acknowledge pacing
	input  wire logic [3:0] ack_delay,
	// NMI handshake
	input  wire logic       nmi_req,
	output logic            nmi_ack
);
	logic [3:0] wait_ff;

	// Accepts a pending NMI after ack_delay cycles with a one-cycle acknowledge.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			wait_ff <= 4'h0;
			nmi_ack <= 1'b0;
		end else begin
			nmi_ack <= 1'b0;
			if (!nmi_req || nmi_ack) wait_ff <= 4'h0;
			else if (wait_ff == ack_delay) nmi_ack <= 1'b1;
			else wait_ff <= wait_ff + 4'h1;
		end
	end
endmodule : pic_core_model

`default_nettype wire

// File: verification/pic_ctrl_tb.sv
/*
 * Self-checking bench for pic_ctrl: registers, arbitration, NMI and status interrupt.
 * Assumes the core model answers NMI requests and the bench plays the peripheral units.
 */
`timescale 1ns/10ps
`default_nettype none

module pic_ctrl_tb;
	logic        clk_sys, nrst, reg_wr, reg_rd, nmi_pin, cpu_irq_req, nmi_req, irq, nmi_ack;
	logic        rd_d;
	logic [7:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata, pa, pb;
	logic [13:0] periph_req;
	logic [3:0]  cpu_int_mask, cpu_irq_level, ack_delay;
	logic [11:0] event_code_reg;
	logic [16:0] notes[$];
	int          n_errors, checks_done, seed, i, k;

	pic_ctrl u_pic_ctrl (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.periph_req(periph_req), .nmi_pin(nmi_pin), .cpu_int_mask(cpu_int_mask),
		.nmi_ack(nmi_ack), .cpu_irq_req(cpu_irq_req), .cpu_irq_level(cpu_irq_level),
		.event_code_reg(event_code_reg), .nmi_req(nmi_req), .irq(irq));

	pic_core_model u_pic_core_model (.clk_sys(clk_sys), .nrst(nrst), .ack_delay(ack_delay),
		.nmi_req(nmi_req), .nmi_ack(nmi_ack));

	// ****************************************************************
	// Checking helpers
	// ****************************************************************
	task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up

	// Returns {forwarded, level, code} of the winning peripheral cause.
	function automatic logic [16:0] pick(input logic [13:0] rq, input logic [15:0] a,
		input logic [15:0] b, input logic [3:0] m);
		logic [3:0]  lv, best;
		logic [11:0] code;
		best = 4'h0;
		code = 12'h000;
		for (int c = 0; c < 14; c++) begin
			lv = c < 4 ? a[15-4*(c-c/3) -: 4] : c < 7 ? a[3:0] : c < 11 ? b[7:4] :
				c == 11 ? b[15:12] : b[11:8];
			if (rq[c] && lv > best) begin
				best = lv;
				code = 12'h400 + 12'h020 * 12'(c);
			end
		end
		return {best > m, best, code};
	endfunction : pick

	// ****************************************************************
	// Register port driver and read watcher
	// ****************************************************************
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		@(posedge clk_sys);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		notes.push_back({1'b0, exp});
		@(posedge clk_sys);
		reg_rd <= 1'b0;
	endtask : rd

	always @(posedge clk_sys) begin
		if (rd_d) chk("read data", notes.pop_front(), {1'b0, reg_rdata});
		rd_d = reg_rd;
	end

	task automatic nmi_run(input logic rise);
		wr(8'h08, {7'h00, rise, 8'h00});
		nmi_pin <= rise;
		repeat (12) @(posedge clk_sys);
		wr(8'h0C, 16'h0003);
		nmi_pin <= ~rise;
		repeat (6) @(posedge clk_sys);
		chk("nmi on other edge", 17'h0, {16'h0, nmi_req});
		rd(8'h08, {~rise, 6'h00, rise, 8'h00});
		nmi_pin <= rise;
		for (i = 0; i < 10 && nmi_req !== 1'b1; i++) @(posedge clk_sys);
		chk("nmi code", {5'h0, 12'h1C0}, {5'h0, event_code_reg});
		chk("status irq", 17'h1, {16'h0, irq});
		for (i = 0; i < 24 && nmi_req !== 1'b0; i++) @(posedge clk_sys);
		chk("nmi after ack", 17'h0, {16'h0, nmi_req});
		$display("test nmi edge %0d done", rise);
	endtask : nmi_run

	// ****************************************************************
	// Clock, watchdog and main sequence
	// ****************************************************************
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	initial begin
		#400_000;
		n_errors++;
		wrap_up();
	end

	initial begin
		seed = 28;
		n_errors = 0;
		checks_done = 0;
		rd_d = 1'b0;
		nrst = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		nmi_pin = 1'b1;
		periph_req = 14'h0000;
		cpu_int_mask = 4'h0;
		ack_delay = 4'h6;
		repeat (20) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (4) @(posedge clk_sys);
		rd(8'h00, 16'h0000);
		rd(8'h04, 16'h0000);
		rd(8'h08, 16'h8000);
		wr(8'h04, 16'hFFF0);
		rd(8'h04, 16'hFFF0);
		wr(8'h08, 16'h0100);
		rd(8'h08, 16'h8100);
		rd(8'h14, 16'h0000);
		$display("test registers done");
		for (k = 0; k < 60; k++) begin
			pa = 16'($random(seed));
			pb = 16'($random(seed)) & 16'hFFF0;
			wr(8'h00, pa);
			wr(8'h04, pb);
			periph_req   <= 14'($random(seed));
			cpu_int_mask <= 4'($random(seed));
			repeat (3) @(posedge clk_sys);
			chk("arbitration", pick(periph_req, pa, pb, cpu_int_mask),
				{cpu_irq_req, cpu_irq_level, event_code_reg});
		end
		rd(8'h00, pa);
		periph_req <= 14'h0000;
		wr(8'h0C, 16'h0003);
		wr(8'h00, 16'h0005);
		periph_req   <= 14'h0010;
		cpu_int_mask <= 4'h2;
		repeat (3) @(posedge clk_sys);
		chk("alarm", {1'b1, 4'h5, 12'h480}, {cpu_irq_req, cpu_irq_level, event_code_reg});
		wr(8'h00, 16'h5005);
		periph_req <= 14'h0011;
		repeat (3) @(posedge clk_sys);
		chk("tie", {1'b1, 4'h5, 12'h400}, {cpu_irq_req, cpu_irq_level, event_code_reg});
		rd(8'h0C, 16'h0002);
		periph_req <= 14'h0000;
		$display("test arbitration done");
		wr(8'h10, 16'h0001);
		nmi_run(1'b1);
		ack_delay <= 4'h0;
		nmi_run(1'b0);
		wr(8'h10, 16'h0000);
		repeat (2) @(posedge clk_sys);
		chk("masked irq", 17'h0, {16'h0, irq});
		rd(8'h0C, 16'h0001);
		wr(8'h0C, 16'h0001);
		rd(8'h0C, 16'h0000);
		$display("test status done");
		repeat (2) @(posedge clk_sys);
		wrap_up();
	end
endmodule : pic_ctrl_tb

`default_nettype wire
